/* sam_cfg_reg.v */
// Startup configuration register captured once per reset release.
`default_nettype none

module sam_cfg_reg (
	// Clock and reset
	input wire REF_CLK,
	input wire RESET,
	// Capture
	input wire load,
	input wire [31:0] word,
	// Held value
	output reg [31:0] value,
	output reg valid
);

	always @(posedge REF_CLK) begin
		if (RESET) begin
			value <= 32'h0000_0000;
			valid <= 1'b0;
		end else if (load && !valid) begin
			value <= word;
			valid <= 1'b1;
		end
	end

endmodule // sam_cfg_reg

`default_nettype wire

/* sam_cpu_model.sv */
// Processor bus master model that feeds requests to the decoder.
`default_nettype none
module sam_cpu_model (
	// Clock
	input wire logic clk,
	// Request
	output logic req,
	output logic [23:0] addr,
	output logic [1:0] size,
	output logic wr,
	// Memory read data
	output logic [31:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] image_id = 16'h0000;
	initial begin
		req = 1'b0;
		addr = 24'h00_0000;
		size = 2'h0;
		wr = 1'b0;
		rdata = 32'h0000_0000;
	end
	// Requests change on the falling edge and hold a whole cycle.
	task automatic access(input logic [23:0] a, input logic [1:0] s);
		@(negedge clk);
		req = 1'b1;
		addr = a;
		size = s;
		// Only the identifier slot reads real data, so stale data toggles.
		rdata = (a == 24'h00_0028) ? {image_id, image_id} : ~rdata;
	endtask
	task automatic idle();
		@(negedge clk);
		req = 1'b0;
		addr = ~addr;
		rdata = ~rdata;
	endtask
endmodule // sam_cpu_model
`default_nettype wire

/* sam_decoder.v */
// Physical address decoder with boot map selection and debug lock.
`default_nettype none
`include "sam_map.vh"

module sam_decoder (
	// Clock and reset
	input wire REF_CLK,
	input wire RESET,
	// Straps
	input wire SECONDARY_TEST_STRAP,
	input wire TEST_STRAP,
	// Processor bus request
	input wire REQ,
	input wire [23:0] ADDR,
	input wire [1:0] SIZE,
	input wire WRITE,
	// Read data from the selected memory
	input wire [31:0] RDATA_IN,
	// Fixed configuration words of the boot memories
	input wire [31:0] ROM_CFG_WORD,
	input wire [31:0] ROM_LOCK_WORD,
	input wire [31:0] BFW_CFG_WORD,
	// Decoded access
	output reg [3:0] TARGET,
	output reg [23:0] LOCAL_ADDR,
	output reg [3:0] WAIT_STATES,
	output reg [5:0] BUS_WIDTH,
	output reg SYNC_BUS,
	output reg SEL_VALID,
	output reg ACCESS_FAULT,
	output reg RESERVED_HIT,
	output reg VECTOR_HIT,
	// Boot state
	output reg [1:0] ZERO_MAP,
	output reg CFG_VALID,
	output reg DEBUG_ENABLE,
	output reg [31:0] STARTUP_CFG,
	output reg [15:0] PROGRAM_IMAGE_ID
);

	// ------------------------------------------------------------------
	// Startup configuration capture
	// ------------------------------------------------------------------
	reg strap_hi;
	reg strap_lo;
	reg booting;
	wire [31:0] cfg_value;
	wire cfg_held;
	wire [31:0] src_word;

	// Straps are sampled in the first cycle after release.
	always @(posedge REF_CLK) begin
		if (RESET) begin
			strap_hi <= 1'b0;
			strap_lo <= 1'b0;
			booting <= 1'b1;
		end else if (booting) begin
			strap_hi <= SECONDARY_TEST_STRAP;
			strap_lo <= TEST_STRAP;
			booting <= 1'b0;
		end
	end

	assign src_word = strap_hi ? BFW_CFG_WORD : ROM_CFG_WORD;

	// The register keeps the first word it takes until the next reset.
	sam_cfg_reg u_cfg (
		.REF_CLK(REF_CLK),
		.RESET(RESET),
		.load(!booting),
		.word(src_word),
		.value(cfg_value),
		.valid(cfg_held)
	);

	// ------------------------------------------------------------------
	// Zero map and debug port
	// ------------------------------------------------------------------
	wire [1:0] zsel;
	wire rom_remap;
	wire lock_set;
	reg [1:0] next_zero_map;

	assign zsel = cfg_value[`SAM_CW_ZSEL_LSB+1:`SAM_CW_ZSEL_LSB];
	assign rom_remap = cfg_held && cfg_value[`SAM_CW_ROMREMAP];
	// Erased flash reads all ones, which leaves the port open.
	assign lock_set = (ROM_LOCK_WORD == `SAM_LOCK_KEY);

	// Before the register is loaded ROM or boot firmware sits at zero.
	always @* begin
		if (!cfg_held) begin
			next_zero_map = SECONDARY_TEST_STRAP ? `SAM_Z_BFW : `SAM_Z_ROM;
		end else begin
			next_zero_map = zsel;
		end
	end

	// ------------------------------------------------------------------
	// Debug port gate
	// ------------------------------------------------------------------
	reg next_debug;

	// The port stays shut until the word is held; a firmware boot
	// follows the firmware word rather than the lock vector.
	always @* begin
		if (!cfg_held) begin
			next_debug = 1'b0;
		end else if (strap_hi) begin
			next_debug = cfg_value[`SAM_CW_DBGEN];
		end else if (!strap_lo) begin
			next_debug = !lock_set;
		end else begin
			next_debug = 1'b0;
		end
	end

	always @(posedge REF_CLK) begin
		if (RESET) begin
			ZERO_MAP <= `SAM_Z_ROM;
			CFG_VALID <= 1'b0;
			DEBUG_ENABLE <= 1'b0;
			STARTUP_CFG <= 32'h0000_0000;
		end else begin
			ZERO_MAP <= next_zero_map;
			CFG_VALID <= cfg_held;
			STARTUP_CFG <= cfg_value;
			DEBUG_ENABLE <= next_debug;
		end
	end

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	reg [3:0] next_target;
	reg [23:0] next_local;
	reg [3:0] next_wait;
	reg [5:0] next_width;
	reg next_sync;
	reg next_fault;
	reg next_res;
	reg next_vec;
	reg zero_hit;

	// Decode is combinational; the request is registered further down.
	always @* begin
		next_target = `SAM_T_NONE;
		next_local = 24'h00_0000;
		next_wait = 4'h0;
		next_width = 6'd32;
		next_sync = 1'b0;
		next_fault = 1'b0;
		next_res = 1'b0;
		next_vec = 1'b0;
		zero_hit = 1'b0;
		// The zero window is tested first, so a remapped ROM keeps
		// its whole span there, its home overlap included.
		if (ZERO_MAP == `SAM_Z_ROM &&
			ADDR <= `SAM_ROM_ZERO_LAST) begin
			zero_hit = 1'b1;
			next_target = `SAM_T_ROM;
			next_local = ADDR;
			next_wait = `SAM_ROM_WAIT;
			next_width = 6'd16;
		end else if (ZERO_MAP == `SAM_Z_RAM &&
			ADDR <= `SAM_RAM_ZERO_LAST) begin
			zero_hit = 1'b1;
			next_target = `SAM_T_RAM;
			next_local = ADDR;
		end else if (ZERO_MAP == `SAM_Z_BFW &&
			ADDR <= `SAM_BFW_ZERO_LAST) begin
			zero_hit = 1'b1;
			next_target = `SAM_T_BFW;
			next_local = ADDR;
		end else if (ADDR >= `SAM_ROM_BASE && ADDR <= `SAM_ROM_LAST) begin
			if (!(rom_remap && ZERO_MAP == `SAM_Z_ROM)) begin
				next_target = `SAM_T_ROM;
				next_local = ADDR - `SAM_ROM_BASE;
				next_wait = `SAM_ROM_WAIT;
				next_width = 6'd16;
			end
		end else if (ADDR >= `SAM_RAM_BASE && ADDR <= `SAM_RAM_LAST) begin
			// Reset leaves the RAM itself alone,
			// so its contents survive it.
			next_target = `SAM_T_RAM;
			next_local = ADDR - `SAM_RAM_BASE;
		end else if (ADDR >= `SAM_BFW_BASE && ADDR <= `SAM_BFW_LAST) begin
			next_target = `SAM_T_BFW;
			next_local = ADDR - `SAM_BFW_BASE;
		end else if (ADDR >= `SAM_IO32_BASE) begin
			next_width = 6'd32;
			if (ADDR >= `SAM_INTC_BASE) begin
				next_target = `SAM_T_INTC;
				next_local = ADDR - `SAM_INTC_BASE;
			end else if (ADDR >= `SAM_DMA_BASE) begin
				next_target = `SAM_T_DMA;
				next_local = ADDR - `SAM_DMA_BASE;
			end else if (ADDR >= `SAM_CORE_BASE) begin
				next_target = `SAM_T_CORE;
				next_local = ADDR - `SAM_CORE_BASE;
			end else begin
				next_target = `SAM_T_IO32;
				next_local = ADDR - `SAM_IO32_BASE;
			end
		end else if (ADDR >= `SAM_IO_BASE) begin
			next_width = 6'd8;
			next_sync = 1'b1;
			next_wait = `SAM_IO8_WAIT;
			// Wider accesses do not fit the byte bus.
			next_fault = (SIZE != 2'b00);
			if (ADDR >= `SAM_PERI_BASE && ADDR <= `SAM_PERI_LAST) begin
				next_target = `SAM_T_PERI;
				next_local = ADDR - `SAM_PERI_BASE;
			end else if (ADDR >= `SAM_CANR_BASE &&
				ADDR <= `SAM_CANR_LAST) begin
				next_target = `SAM_T_CANR;
				next_local = ADDR - `SAM_CANR_BASE;
			end else if (ADDR <= `SAM_CANM_LAST) begin
				next_target = `SAM_T_CANM;
				next_local = ADDR - `SAM_IO_BASE;
			end else begin
				next_target = `SAM_T_IO8;
				next_local = ADDR - `SAM_IO_BASE;
			end
		end
		// Holes between regions select nothing and count as faults.
		if (next_target == `SAM_T_NONE) begin
			next_fault = 1'b1;
		end
		// Vector words matter for any memory at zero; reserved words only for ROM or firmware there.
		next_vec = zero_hit && ADDR <= `SAM_VEC_LAST;
		next_res = zero_hit && ZERO_MAP != `SAM_Z_RAM &&
			ADDR >= `SAM_CFG_OFS && ADDR <= `SAM_OPT_LAST;
	end

	// ------------------------------------------------------------------
	// Registered decode outputs
	// ------------------------------------------------------------------
	always @(posedge REF_CLK) begin
		if (RESET) begin
			TARGET <= `SAM_T_NONE;
			LOCAL_ADDR <= 24'h00_0000;
			WAIT_STATES <= 4'h0;
			BUS_WIDTH <= 6'd32;
			SYNC_BUS <= 1'b0;
			SEL_VALID <= 1'b0;
			ACCESS_FAULT <= 1'b0;
			RESERVED_HIT <= 1'b0;
			VECTOR_HIT <= 1'b0;
		end else begin
			TARGET <= REQ ? next_target : `SAM_T_NONE;
			LOCAL_ADDR <= REQ ? next_local : 24'h00_0000;
			WAIT_STATES <= REQ ? next_wait : 4'h0;
			BUS_WIDTH <= next_width;
			SYNC_BUS <= REQ && next_sync;
			SEL_VALID <= REQ && !next_fault;
			ACCESS_FAULT <= REQ && next_fault;
			RESERVED_HIT <= REQ && next_res;
			VECTOR_HIT <= REQ && next_vec;
		end
	end

	// ------------------------------------------------------------------
	// Program image identifier snoop
	// ------------------------------------------------------------------
	wire id_read;

	// Only a read of the identifier half-word with a boot memory at
	// zero is kept; the value is for outside equipment alone.
	assign id_read = REQ && next_res && !WRITE &&
		{ADDR[23:1], 1'b0} == `SAM_PIID_OFS;

	always @(posedge REF_CLK) begin
		if (RESET) begin
			PROGRAM_IMAGE_ID <= 16'h0000;
		end else if (id_read) begin
			PROGRAM_IMAGE_ID <= RDATA_IN[15:0];
		end
	end

endmodule // sam_decoder

`default_nettype wire

/* sam_decoder_chk.sv */
// Concurrent checks on the ports of the address decoder.
`default_nettype none
`include "sam_map.vh"
module sam_decoder_chk (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	// Straps and boot words
	input wire logic SECONDARY_TEST_STRAP,
	input wire logic TEST_STRAP,
	input wire logic [31:0] ROM_LOCK_WORD,
	// Request
	input wire logic REQ,
	input wire logic [23:0] ADDR,
	input wire logic [1:0] SIZE,
	// Decode and boot state
	input wire logic [3:0] TARGET,
	input wire logic [23:0] LOCAL_ADDR,
	input wire logic [3:0] WAIT_STATES,
	input wire logic [5:0] BUS_WIDTH,
	input wire logic SYNC_BUS,
	input wire logic SEL_VALID,
	input wire logic ACCESS_FAULT,
	input wire logic RESERVED_HIT,
	input wire logic VECTOR_HIT,
	input wire logic [1:0] ZERO_MAP,
	input wire logic CFG_VALID,
	input wire logic DEBUG_ENABLE,
	input wire logic [31:0] STARTUP_CFG
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	wire logic in_rom = ADDR >= `SAM_ROM_BASE && ADDR <= `SAM_ROM_LAST;
	wire logic in_ram = ADDR >= `SAM_RAM_BASE && ADDR <= `SAM_RAM_LAST;
	wire logic in_io8 = ADDR >= `SAM_IO_BASE && ADDR <= `SAM_IO8_LAST;
	wire logic remap = CFG_VALID && STARTUP_CFG[`SAM_CW_ROMREMAP] &&
		ZERO_MAP == `SAM_Z_ROM;
	ram_home_a: assert property (REQ && in_ram |=> TARGET == `SAM_T_RAM &&
		LOCAL_ADDR == $past(ADDR) - `SAM_RAM_BASE && WAIT_STATES == 4'h0)
		else $error("ram decode wrong");
	rom_home_a: assert property (REQ && in_rom && CFG_VALID && !remap
		|=> TARGET == `SAM_T_ROM && WAIT_STATES == `SAM_ROM_WAIT &&
		BUS_WIDTH == 6'h10) else $error("rom decode wrong");
	rom_gone_a: assert property (REQ && in_rom && remap &&
		ADDR > `SAM_ROM_ZERO_LAST |=> ACCESS_FAULT && !SEL_VALID)
		else $error("remapped rom answered");
	io8_bus_a: assert property (REQ && in_io8 && SIZE == 2'h0 |=> SYNC_BUS &&
		BUS_WIDTH == 6'h08 && WAIT_STATES == `SAM_IO8_WAIT)
		else $error("io8 bus wrong");
	io32_bus_a: assert property (REQ && ADDR >= `SAM_IO32_BASE |=> !SYNC_BUS
		&& BUS_WIDTH == 6'h20 && WAIT_STATES == 4'h0)
		else $error("io32 bus wrong");
	boot_hold_a: assert property (CFG_VALID |=> CFG_VALID &&
		$stable(ZERO_MAP) && $stable(STARTUP_CFG)) else $error("boot map moved");
	fw_boot_a: assert property (CFG_VALID && SECONDARY_TEST_STRAP
		|-> STARTUP_CFG == `SAM_BFW_CW && ZERO_MAP == `SAM_Z_BFW &&
		!DEBUG_ENABLE) else $error("firmware boot wrong");
	lock_open_a: assert property ($rose(CFG_VALID) && !SECONDARY_TEST_STRAP
		&& !TEST_STRAP && ROM_LOCK_WORD != `SAM_LOCK_KEY
		|-> ##[0:2] DEBUG_ENABLE) else $error("debug stayed closed");
	vec_hit_a: assert property (REQ && ADDR <= `SAM_VEC_LAST &&
		ZERO_MAP != `SAM_Z_NONE |=> VECTOR_HIT && SEL_VALID)
		else $error("vector hit missing");
	res_hit_a: assert property (REQ && ADDR >= `SAM_CFG_OFS &&
		ADDR <= `SAM_OPT_LAST |=> RESERVED_HIT == ($past(ZERO_MAP) ==
		`SAM_Z_ROM || $past(ZERO_MAP) == `SAM_Z_BFW))
		else $error("reserved hit wrong");
	cover property (REQ && in_rom && remap);
	cover property ($rose(CFG_VALID) && SECONDARY_TEST_STRAP);
	cover property (REQ && in_io8 && SIZE == 2'h0);
endmodule // sam_decoder_chk
bind sam_decoder sam_decoder_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET),
	.SECONDARY_TEST_STRAP(SECONDARY_TEST_STRAP), .TEST_STRAP(TEST_STRAP),
	.ROM_LOCK_WORD(ROM_LOCK_WORD), .REQ(REQ), .ADDR(ADDR), .SIZE(SIZE),
	.TARGET(TARGET), .LOCAL_ADDR(LOCAL_ADDR), .WAIT_STATES(WAIT_STATES),
	.BUS_WIDTH(BUS_WIDTH), .SYNC_BUS(SYNC_BUS), .SEL_VALID(SEL_VALID),
	.ACCESS_FAULT(ACCESS_FAULT), .RESERVED_HIT(RESERVED_HIT),
	.VECTOR_HIT(VECTOR_HIT), .ZERO_MAP(ZERO_MAP), .CFG_VALID(CFG_VALID),
	.DEBUG_ENABLE(DEBUG_ENABLE), .STARTUP_CFG(STARTUP_CFG));
`default_nettype wire

/* sam_map.vh */
// Address map, region codes and reset-time constants of the address decoder.
`ifndef SAM_MAP_VH
`define SAM_MAP_VH

// ----------------------------------------------------------------------
// Region bounds (24-bit physical byte addresses)
// ----------------------------------------------------------------------
`define SAM_ROM_BASE 24'h20_0000
`define SAM_ROM_LAST 24'h9F_FFFF
`define SAM_ROM_ZERO_LAST 24'h7F_FFFF
`define SAM_RAM_BASE 24'hC0_0000
`define SAM_RAM_LAST 24'hDF_FFFF
`define SAM_RAM_ZERO_LAST 24'h1F_FFFF
`define SAM_BFW_BASE 24'hF0_0000
`define SAM_BFW_LAST 24'hF7_FFFF
`define SAM_BFW_ZERO_LAST 24'h07_FFFF
`define SAM_IO_BASE 24'hF8_0000
`define SAM_IO8_LAST 24'hFB_FFFF
`define SAM_IO32_BASE 24'hFC_0000
`define SAM_IO_LAST 24'hFF_FFFF

// ----------------------------------------------------------------------
// I/O sub-blocks
// ----------------------------------------------------------------------
`define SAM_INTC_BASE 24'hFF_FF00
`define SAM_DMA_BASE 24'hFF_FE00
`define SAM_DMA_LAST 24'hFF_FEFF
`define SAM_CORE_BASE 24'hFF_FC00
`define SAM_CORE_LAST 24'hFF_FDFF
`define SAM_PERI_BASE 24'hF9_0000
`define SAM_PERI_LAST 24'hF9_07FF
`define SAM_CANR_BASE 24'hF8_1000
`define SAM_CANR_LAST 24'hF8_11FF
`define SAM_CANM_LAST 24'hF8_0FFF

// ----------------------------------------------------------------------
// Reserved words at address zero (byte offsets)
// ----------------------------------------------------------------------
`define SAM_VEC_LAST 24'h00_001F
`define SAM_CFG_OFS 24'h00_0020
`define SAM_LOCK_OFS 24'h00_0024
`define SAM_PIID_OFS 24'h00_0028
`define SAM_MFID_OFS 24'h00_002C
`define SAM_OPT_BASE 24'h00_0030
`define SAM_OPT_LAST 24'h00_005F
`define SAM_LOCK_KEY 32'h55AA_55AA

// ----------------------------------------------------------------------
// Target codes and zero-map selections
// ----------------------------------------------------------------------
`define SAM_T_NONE 4'h0
`define SAM_T_ROM 4'h1
`define SAM_T_RAM 4'h2
`define SAM_T_BFW 4'h3
`define SAM_T_INTC 4'h4
`define SAM_T_DMA 4'h5
`define SAM_T_CORE 4'h6
`define SAM_T_IO32 4'h7
`define SAM_T_PERI 4'h8
`define SAM_T_CANR 4'h9
`define SAM_T_CANM 4'hA
`define SAM_T_IO8 4'hB
`define SAM_Z_ROM 2'h0
`define SAM_Z_RAM 2'h1
`define SAM_Z_BFW 2'h2
`define SAM_Z_NONE 2'h3

// ----------------------------------------------------------------------
// Startup configuration word fields and wait states
// ----------------------------------------------------------------------
`define SAM_CW_ZSEL_LSB 0
`define SAM_CW_ROMREMAP 2
`define SAM_CW_DBGEN 3
`define SAM_BFW_CW 32'h0000_0002
`define SAM_ROM_WAIT 4'h2
`define SAM_IO16_WAIT 4'h2
`define SAM_IO8_WAIT 4'h3

`endif

/* system_address_map_decoder_tb_top.sv */
// Self-checking bench of the address decoder.
`default_nettype none
`include "sam_map.vh"
module system_address_map_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic REF_CLK = 1'b0;
	logic RESET = 1'b1;
	logic sec = 1'b0;
	logic tst = 1'b0;
	logic [31:0] cw = 32'h0000_0000;
	logic [31:0] lock = 32'h0000_0000;
	logic [31:0] seed = 32'h4ad5_7bad;
	logic taken = 1'b0;
	wire logic req, wr;
	wire logic [23:0] addr;
	wire logic [1:0] size;
	wire logic [31:0] rdata;
	logic [3:0] target;
	logic [23:0] local_addr;
	logic [31:0] stcfg;
	logic [15:0] piid;
	logic [1:0] zmap;
	logic fault, cfgv, dbg;
	logic [28:0] notes[$];
	logic [28:0] n;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	localparam logic [28:0] FLT = 29'h1000_0000;
	sam_cpu_model cpu (.clk(REF_CLK), .req(req), .addr(addr), .size(size),
		.wr(wr), .rdata(rdata));
	sam_decoder dut (.REF_CLK(REF_CLK), .RESET(RESET),
		.SECONDARY_TEST_STRAP(sec), .TEST_STRAP(tst), .REQ(req),
		.ADDR(addr), .SIZE(size), .WRITE(wr), .RDATA_IN(rdata),
		.ROM_CFG_WORD(cw), .ROM_LOCK_WORD(lock), .BFW_CFG_WORD(`SAM_BFW_CW),
		.TARGET(target), .LOCAL_ADDR(local_addr), .WAIT_STATES(),
		.BUS_WIDTH(), .SYNC_BUS(), .SEL_VALID(), .ACCESS_FAULT(fault),
		.RESERVED_HIT(), .VECTOR_HIT(), .ZERO_MAP(zmap), .CFG_VALID(cfgv),
		.DEBUG_ENABLE(dbg), .STARTUP_CFG(stcfg), .PROGRAM_IMAGE_ID(piid));
	initial forever #5 REF_CLK = ~REF_CLK;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic report_and_stop();
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Note the expected decode, then let the bus master issue the request.
	task automatic go(input logic [23:0] a, input logic [1:0] s,
		input logic [3:0] t, input logic [23:0] l, input logic f);
		notes.push_back(f ? FLT : {1'b0, t, l});
		cpu.access(a, s);
	endtask
	task automatic boot(input logic s, input logic [31:0] c,
		input logic [31:0] k);
		@(negedge REF_CLK);
		RESET = 1'b1;
		sec = s;
		cw = c;
		lock = k;
		repeat (12) @(negedge REF_CLK);
		RESET = 1'b0;
		repeat (6) @(negedge REF_CLK);
		chk("cfg_valid", 1, cfgv);
	endtask
	always @(posedge REF_CLK) begin
		taken <= req && !RESET;
		cyc++;
		if (cyc == 3000) begin
			fails++;
			report_and_stop();
		end
	end
	always @(negedge REF_CLK) begin
		if (taken) begin
			n = notes.pop_front();
			if (n[28])
				chk("fault", 1, fault);
			else
				chk("decode", n, {fault, target, local_addr});
		end
	end
	initial begin : main
		logic [23:0] off;
		logic [15:0] id;
		logic [23:0] io_a[6];
		logic [3:0] io_t[6];
		io_a = '{`SAM_INTC_BASE, `SAM_DMA_BASE, `SAM_CORE_BASE,
			`SAM_PERI_BASE, `SAM_CANR_BASE, 24'hF8_0000};
		io_t = '{`SAM_T_INTC, `SAM_T_DMA, `SAM_T_CORE, `SAM_T_PERI,
			`SAM_T_CANR, `SAM_T_CANM};
		id = 16'(xs());
		cpu.image_id = id;
		boot(1'b0, 32'h0000_0004, `SAM_LOCK_KEY);
		chk("zero_map", `SAM_Z_ROM, zmap);
		chk("debug", 0, dbg);
		go(24'h00_0028, 2'h1, `SAM_T_ROM, 24'h00_0028, 1'b0);
		go(24'h7F_FFFC, 2'h2, `SAM_T_ROM, 24'h7F_FFFC, 1'b0);
		go(24'h20_0000, 2'h2, `SAM_T_ROM, 24'h20_0000, 1'b0);
		go(24'h9F_FFFC, 2'h2, 4'h0, 24'h00_0000, 1'b1);
		go(24'h00_0030, 2'h2, `SAM_T_ROM, 24'h00_0030, 1'b0);
		go(24'h80_0000, 2'h2, 4'h0, 24'h00_0000, 1'b1);
		cpu.idle();
		repeat (3) @(negedge REF_CLK);
		chk("image_id", id, piid);
		boot(1'b0, 32'h0000_0001, 32'hFFFF_FFFF);
		chk("debug", 1, dbg);
		go(24'h00_0010, 2'h2, `SAM_T_RAM, 24'h00_0010, 1'b0);
		go(24'h00_0028, 2'h1, `SAM_T_RAM, 24'h00_0028, 1'b0);
		for (int i = 0; i < 8; i++) begin
			off = 24'(xs() & 32'h001F_FFFC);
			go(`SAM_RAM_BASE + off, 2'h2, `SAM_T_RAM, off, 1'b0);
		end
		go(24'h9F_FFFE, 2'h1, `SAM_T_ROM, 24'h7F_FFFE, 1'b0);
		go(24'hA0_0000, 2'h2, 4'h0, 24'h00_0000, 1'b1);
		for (int i = 0; i < 6; i++)
			go(io_a[i], 2'h0, io_t[i], 24'h00_0000, 1'b0);
		go(24'hF8_0000, 2'h2, 4'h0, 24'h00_0000, 1'b1);
		go(24'hFC_0000, 2'h2, `SAM_T_IO32, 24'h00_0000, 1'b0);
		cpu.idle();
		boot(1'b1, 32'h0000_0001, `SAM_LOCK_KEY);
		chk("startup_cfg", `SAM_BFW_CW, stcfg);
		chk("zero_map", `SAM_Z_BFW, zmap);
		go(24'h00_0010, 2'h2, `SAM_T_BFW, 24'h00_0010, 1'b0);
		go(24'hF0_0010, 2'h2, `SAM_T_BFW, 24'h00_0010, 1'b0);
		cpu.idle();
		boot(1'b0, 32'h0000_000B, 32'h0000_0000);
		chk("debug", 1, dbg);
		chk("zero_map", `SAM_Z_NONE, zmap);
		go(24'h00_0010, 2'h2, 4'h0, 24'h00_0000, 1'b1);
		go(24'h80_0000, 2'h2, `SAM_T_ROM, 24'h60_0000, 1'b0);
		cpu.idle();
		tst = 1'b1;
		boot(1'b0, 32'h0000_0008, 32'hFFFF_FFFF);
		chk("debug", 0, dbg);
		repeat (2) @(negedge REF_CLK);
		report_and_stop();
	end
endmodule // system_address_map_decoder_tb_top
`default_nettype wire
